/* File: rtl/sense_thr_pkg.sv */
// Function
// RQ1 - effective touch threshold is register value times four plus four, 4 to 1024
// RQ2 - touch threshold copied from programmed bank 1 at start up, then register only
// RQ3 - movement threshold copied from programmed bank 1 at start up, then register only
// RQ4 - movement threshold of zero makes movement trigger on every evaluation
// RQ5 - proximity threshold loaded from programmed bank 1 at start up, then register only
// RQ6 - proximity threshold held within 4..10, or 8..14 when select pin high outside I2C; code clamps only on load and write, reset gives 4 in both spans
// RQ7 - host keeps drift tracking value low, 0 to 255, reset value 3
// RQ8 - per-channel sensitivity multiplier field of 0 to 15 scales sensitivity
// RQ9 - proximity threshold in low four bits, upper four reserved, read zero
package sense_thr_pkg;
	// register map
	localparam logic [7:0] move_level_addr       = 8'h09;
	localparam logic [7:0] touch_level_addr      = 8'h0a;
	localparam logic [7:0] near_level_addr       = 8'h0b;
	localparam logic [7:0] drift_tracking_addr   = 8'h0c;
	localparam logic [7:0] first_scaling_addr    = 8'h0d;
	localparam logic [7:0] first_trim_addr       = 8'h0e;
	localparam logic [7:0] second_scaling_addr   = 8'h0f;
	localparam logic [7:0] second_trim_addr      = 8'h10;

	// reset values
	localparam logic [7:0] drift_tracking_rst    = 8'h03;
	localparam logic [7:0] level_rst             = 8'h00;

	// proximity spans
	localparam logic [3:0] near_low_min          = 4'h4;
	localparam logic [3:0] near_low_max          = 4'ha;
	localparam logic [3:0] near_high_min         = 4'h8;
	localparam logic [3:0] near_high_max         = 4'he;

	// field layout
	localparam int         sens_lsb              = 0;
	localparam int         sens_msb              = 3;
	localparam int         comp_lsb              = 4;
	localparam int         comp_msb              = 5;
	localparam logic [10:0] touch_offset         = 11'h004;
	localparam int          touch_shift          = 2;

	// i2c
	localparam logic [6:0] dev_addr_default      = 7'h2a; // arbitrary value
	localparam logic [3:0] byte_bits             = 4'h8;
	localparam logic [3:0] last_tx_bit           = 4'h7;

	// bank 1 programmed values, loaded once at start up
	typedef struct packed {
		logic [7:0] touch_level;
		logic [7:0] move_level;
		logic [3:0] near_level;
	} otp_bank_s;

	// live settings for the sensing engine
	typedef struct packed {
		logic [10:0] touch_threshold;
		logic [7:0]  move_level;
		logic        move_always;
		logic [3:0]  near_level;
		logic [7:0]  drift_rate;
		logic [3:0]  first_sens_mult;
		logic [1:0]  first_comp_mult;
		logic [7:0]  first_trim;
		logic [3:0]  second_sens_mult;
		logic [1:0]  second_comp_mult;
		logic [7:0]  second_trim;
	} sense_cfg_s;

	typedef enum logic [2:0] {
		st_idle, st_addr, st_ack, st_ptr, st_wr, st_rd, st_rack
	} i2c_state_e;
endpackage

/* File: rtl/sensing_threshold_registers.sv */
`timescale 1ns/1ps
module sensing_threshold_registers #(
	parameter logic [6:0] dev_addr = sense_thr_pkg::dev_addr_default
) (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     rst,
	// start up load from programmed bank 1
	input  wire logic                     otp_load,
	input  wire sense_thr_pkg::otp_bank_s otp_bank,
	// mode and strap
	input  wire logic                     i2c_mode,
	input  wire logic                     threshold_select_pin,
	// i2c pins, open drain
	input  wire logic                     scl_in,
	input  wire logic                     sda_in,
	output logic                          sda_out,
	output logic                          sda_oe,
	// settings to the sensing engine
	output sense_thr_pkg::sense_cfg_s     cfg
);
	logic [2:0]               scl_sync_ff;
	logic [2:0]               sda_sync_ff;
	logic [1:0]               sel_sync_ff;
	logic                     scl_rise;
	logic                     scl_fall;
	logic                     start_cond;
	logic                     stop_cond;
	sense_thr_pkg::i2c_state_e state_ff;
	sense_thr_pkg::i2c_state_e after_ff;
	logic [7:0]               shift_ff;
	logic [3:0]               cnt_ff;
	logic [7:0]               ptr_ff;
	logic                     sda_oe_ff;
	logic                     wr_stb;
	logic [7:0]               rd_data;
	logic                     high_span;
	logic [7:0]               touch_ff;
	logic [7:0]               move_ff;
	logic [3:0]               near_ff;
	logic [7:0]               drift_ff;
	logic [5:0]               first_scale_ff;
	logic [5:0]               second_scale_ff;
	logic [7:0]               first_trim_ff;
	logic [7:0]               second_trim_ff;
	sense_thr_pkg::sense_cfg_s cfg_ff;

	function automatic logic [3:0] clamp_near(input logic [7:0] val, input logic hi);
		logic [3:0] lo_lim;
		logic [3:0] hi_lim;
		lo_lim = hi ? sense_thr_pkg::near_high_min : sense_thr_pkg::near_low_min;
		hi_lim = hi ? sense_thr_pkg::near_high_max : sense_thr_pkg::near_low_max;
		if (val < {4'h0, lo_lim})
			clamp_near = lo_lim;
		else if (val > {4'h0, hi_lim})
			clamp_near = hi_lim;
		else
			clamp_near = val[3:0];
	endfunction

	// pin synchronisers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			scl_sync_ff <= 3'b111;
			sda_sync_ff <= 3'b111;
			sel_sync_ff <= 2'b00;
		end else begin
			scl_sync_ff <= {scl_sync_ff[1:0], scl_in};
			sda_sync_ff <= {sda_sync_ff[1:0], sda_in};
			sel_sync_ff <= {sel_sync_ff[0], threshold_select_pin};
		end
	end

	assign scl_rise   = scl_sync_ff[1] & ~scl_sync_ff[2];
	assign scl_fall   = ~scl_sync_ff[1] & scl_sync_ff[2];
	assign start_cond = scl_sync_ff[1] & scl_sync_ff[2] & ~sda_sync_ff[1] & sda_sync_ff[2];
	assign stop_cond  = scl_sync_ff[1] & scl_sync_ff[2] & sda_sync_ff[1] & ~sda_sync_ff[2];
	assign high_span  = sel_sync_ff[1] & ~i2c_mode; // [RQ6]
	assign wr_stb     = scl_fall && (state_ff == sense_thr_pkg::st_wr)
	                    && (cnt_ff == sense_thr_pkg::byte_bits);

	// register read mux, reserved bits zero
	always_comb begin
		case (ptr_ff)
			sense_thr_pkg::move_level_addr:     rd_data = move_ff;
			sense_thr_pkg::touch_level_addr:    rd_data = touch_ff;
			sense_thr_pkg::near_level_addr:     rd_data = {4'h0, near_ff}; // [RQ9]
			sense_thr_pkg::drift_tracking_addr: rd_data = drift_ff;
			sense_thr_pkg::first_scaling_addr:  rd_data = {2'b00, first_scale_ff};
			sense_thr_pkg::first_trim_addr:     rd_data = first_trim_ff;
			sense_thr_pkg::second_scaling_addr: rd_data = {2'b00, second_scale_ff};
			sense_thr_pkg::second_trim_addr:    rd_data = second_trim_ff;
			default:                            rd_data = 8'h00;
		endcase
	end

	// i2c slave protocol
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_ff  <= sense_thr_pkg::st_idle;
			after_ff  <= sense_thr_pkg::st_idle;
			shift_ff  <= 8'h00;
			cnt_ff    <= 4'h0;
			ptr_ff    <= 8'h00;
			sda_oe_ff <= 1'b0;
		end else if (start_cond) begin
			state_ff  <= sense_thr_pkg::st_addr;
			cnt_ff    <= 4'h0;
			sda_oe_ff <= 1'b0;
		end else if (stop_cond) begin
			state_ff  <= sense_thr_pkg::st_idle;
			sda_oe_ff <= 1'b0;
		end else if (scl_rise) begin
			case (state_ff)
				sense_thr_pkg::st_addr, sense_thr_pkg::st_ptr, sense_thr_pkg::st_wr: begin
					shift_ff <= {shift_ff[6:0], sda_sync_ff[1]};
					cnt_ff   <= cnt_ff + 4'h1;
				end
				sense_thr_pkg::st_rack: begin
					if (sda_sync_ff[1])
						state_ff <= sense_thr_pkg::st_idle;
				end
				default: begin
				end
			endcase
		end else if (scl_fall) begin
			case (state_ff)
				sense_thr_pkg::st_addr: begin
					if (cnt_ff == sense_thr_pkg::byte_bits) begin
						if (shift_ff[7:1] == dev_addr) begin
							after_ff  <= shift_ff[0] ? sense_thr_pkg::st_rd
							                         : sense_thr_pkg::st_ptr;
							sda_oe_ff <= 1'b1;
							state_ff  <= sense_thr_pkg::st_ack;
						end else begin
							state_ff <= sense_thr_pkg::st_idle;
						end
					end
				end
				sense_thr_pkg::st_ptr: begin
					if (cnt_ff == sense_thr_pkg::byte_bits) begin
						ptr_ff    <= shift_ff;
						after_ff  <= sense_thr_pkg::st_wr;
						sda_oe_ff <= 1'b1;
						state_ff  <= sense_thr_pkg::st_ack;
					end
				end
				sense_thr_pkg::st_wr: begin
					if (cnt_ff == sense_thr_pkg::byte_bits) begin
						ptr_ff    <= ptr_ff + 8'h01;
						after_ff  <= sense_thr_pkg::st_wr;
						sda_oe_ff <= 1'b1;
						state_ff  <= sense_thr_pkg::st_ack;
					end
				end
				sense_thr_pkg::st_ack: begin
					cnt_ff   <= 4'h0;
					state_ff <= after_ff;
					if (after_ff == sense_thr_pkg::st_rd) begin
						shift_ff  <= rd_data;
						sda_oe_ff <= ~rd_data[7];
						ptr_ff    <= ptr_ff + 8'h01;
					end else begin
						sda_oe_ff <= 1'b0;
					end
				end
				sense_thr_pkg::st_rd: begin
					if (cnt_ff == sense_thr_pkg::last_tx_bit) begin
						sda_oe_ff <= 1'b0;
						state_ff  <= sense_thr_pkg::st_rack;
					end else begin
						shift_ff  <= {shift_ff[6:0], 1'b0};
						sda_oe_ff <= ~shift_ff[6];
						cnt_ff    <= cnt_ff + 4'h1;
					end
				end
				sense_thr_pkg::st_rack: begin
					shift_ff  <= rd_data;
					sda_oe_ff <= ~rd_data[7];
					ptr_ff    <= ptr_ff + 8'h01;
					cnt_ff    <= 4'h0;
					state_ff  <= sense_thr_pkg::st_rd;
				end
				default: state_ff <= sense_thr_pkg::st_idle;
			endcase
		end
	end

	// register bank: start up load, then host writes only
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			touch_ff        <= sense_thr_pkg::level_rst;
			move_ff         <= sense_thr_pkg::level_rst;
			near_ff         <= sense_thr_pkg::near_low_min;
			drift_ff        <= sense_thr_pkg::drift_tracking_rst; // [RQ7]
			first_scale_ff  <= 6'h00;
			second_scale_ff <= 6'h00;
			first_trim_ff   <= 8'h00;
			second_trim_ff  <= 8'h00;
		end else if (otp_load) begin
			touch_ff <= otp_bank.touch_level; // [RQ2]
			move_ff  <= otp_bank.move_level; // [RQ3]
			near_ff  <= clamp_near({4'h0, otp_bank.near_level}, high_span); // [RQ5]
		end else if (wr_stb) begin
			case (ptr_ff)
				sense_thr_pkg::move_level_addr:     move_ff <= shift_ff; // [RQ3]
				sense_thr_pkg::touch_level_addr:    touch_ff <= shift_ff; // [RQ2]
				sense_thr_pkg::near_level_addr:
					near_ff <= clamp_near(shift_ff, high_span); // [RQ6] [RQ9]
				sense_thr_pkg::drift_tracking_addr: drift_ff <= shift_ff;
				sense_thr_pkg::first_scaling_addr:  first_scale_ff <= shift_ff[5:0]; // [RQ8]
				sense_thr_pkg::first_trim_addr:     first_trim_ff <= shift_ff;
				sense_thr_pkg::second_scaling_addr: second_scale_ff <= shift_ff[5:0]; // [RQ8]
				sense_thr_pkg::second_trim_addr:    second_trim_ff <= shift_ff;
				default: begin
				end
			endcase
		end
	end

	// derived settings, registered
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_ff <= '0;
		end else begin
			cfg_ff.touch_threshold  <= ({3'b000, touch_ff} << sense_thr_pkg::touch_shift)
			                           + sense_thr_pkg::touch_offset; // [RQ1]
			cfg_ff.move_level       <= move_ff;
			cfg_ff.move_always      <= (move_ff == sense_thr_pkg::level_rst); // [RQ4]
			cfg_ff.near_level       <= near_ff; // [RQ6]
			cfg_ff.drift_rate       <= drift_ff;
			cfg_ff.first_sens_mult  <=
				first_scale_ff[sense_thr_pkg::sens_msb:sense_thr_pkg::sens_lsb]; // [RQ8]
			cfg_ff.first_comp_mult  <=
				first_scale_ff[sense_thr_pkg::comp_msb:sense_thr_pkg::comp_lsb];
			cfg_ff.first_trim       <= first_trim_ff;
			cfg_ff.second_sens_mult <=
				second_scale_ff[sense_thr_pkg::sens_msb:sense_thr_pkg::sens_lsb]; // [RQ8]
			cfg_ff.second_comp_mult <=
				second_scale_ff[sense_thr_pkg::comp_msb:sense_thr_pkg::comp_lsb];
			cfg_ff.second_trim      <= second_trim_ff;
		end
	end

	// open drain: only ever pulls low
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			sda_out <= 1'b0;
		else
			sda_out <= 1'b0;
	end

	assign sda_oe = sda_oe_ff;
	assign cfg    = cfg_ff;
endmodule

/* File: test/sensing_threshold_properties.sv */
`timescale 1ns/1ps
module sensing_threshold_properties (
	// clock and reset
	input wire logic                      clk,
	input wire logic                      rst,
	// load, strap and pins
	input wire logic                      otp_load,
	input wire sense_thr_pkg::otp_bank_s  otp_bank,
	input wire logic                      i2c_mode,
	input wire logic                      threshold_select_pin,
	input wire logic                      scl_in,
	input wire logic                      sda_in,
	input wire logic                      sda_out,
	input wire logic                      sda_oe,
	// settings
	input wire sense_thr_pkg::sense_cfg_s cfg
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence rst_release;
		$past(rst) && !rst;
	endsequence
	sequence low_span_load;
		otp_load && i2c_mode && otp_bank.near_level inside {[4'h4:4'ha]};
	endsequence

	touch_load_a: assert property (otp_load |-> ##2
		cfg.touch_threshold == ({3'h0, $past(otp_bank.touch_level, 2)} << 2) + 11'h004)
		else $error("touch threshold not loaded from bank");
	touch_span_a: assert property (!$past(rst) |-> cfg.touch_threshold[1:0] == 2'h0 &&
		cfg.touch_threshold inside {[11'h004:11'h400]}) else $error("touch threshold off span");
	move_load_a: assert property (otp_load |-> ##2
		cfg.move_level == $past(otp_bank.move_level, 2)) else $error("movement not loaded");
	move_always_a: assert property (!$past(rst) |->
		cfg.move_always == (cfg.move_level == 8'h00)) else $error("movement trigger wrong");
	near_load_a: assert property (low_span_load |-> ##2
		cfg.near_level == $past(otp_bank.near_level, 2)) else $error("proximity not loaded");
	near_span_a: assert property (!$past(rst) |->
		cfg.near_level inside {[4'h4:4'he]}) else $error("proximity off span");
	reset_values_a: assert property (rst_release |=>
		cfg.drift_rate == 8'h03 && cfg.near_level == 4'h4) else $error("bad reset values");
	sens_write_a: assert property ($changed(cfg.first_sens_mult) && !$past(rst) |->
		!scl_in && !$past(otp_load)) else $error("sensitivity changed outside a write");
endmodule

bind sensing_threshold_registers sensing_threshold_properties chk (.clk(clk), .rst(rst),
	.otp_load(otp_load), .otp_bank(otp_bank), .i2c_mode(i2c_mode),
	.threshold_select_pin(threshold_select_pin), .scl_in(scl_in), .sda_in(sda_in),
	.sda_out(sda_out), .sda_oe(sda_oe), .cfg(cfg));

/* File: test/i2c_host_model.sv */
`timescale 1ns/1ps
module i2c_host_model (
	// clock and bus
	input wire logic clk,
	input wire logic sda_line,
	output logic     scl,
	output logic     sda_drv
);
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	// ten clocks per scl half period
	task automatic hold();
		repeat (10) @(negedge clk);
	endtask
	task automatic start();
		sda_drv = 1'b1;
		hold();
		scl = 1'b1;
		hold();
		sda_drv = 1'b0;
		hold();
		scl = 1'b0;
	endtask
	task automatic stop();
		sda_drv = 1'b0;
		hold();
		scl = 1'b1;
		hold();
		sda_drv = 1'b1;
		hold();
	endtask
	task automatic bit_io(input logic b, output logic s);
		sda_drv = b;
		hold();
		scl = 1'b1;
		hold();
		s = sda_line;
		scl = 1'b0;
	endtask
	// msb first, then the ninth bit: released for device ack or host ack/nack
	task automatic byte_io(input logic [7:0] tx, input logic last, output logic [7:0] rx,
		output logic ack);
		for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
		bit_io(last, ack);
	endtask
endmodule

/* File: test/tb_sensing_threshold_registers.sv */
`timescale 1ns/1ps
module tb_sensing_threshold_registers;
	logic                      clk;
	logic                      rst;
	logic                      otp_load;
	sense_thr_pkg::otp_bank_s  otp_bank;
	logic                      i2c_mode;
	logic                      threshold_select_pin;
	logic                      scl;
	logic                      sda_drv;
	logic                      sda_out;
	logic                      sda_oe;
	logic                      sda_line;
	sense_thr_pkg::sense_cfg_s cfg;
	int                        n_errors;
	int                        total_checks;
	// i2c mode, strap, written value, expected level
	logic [19:0]               near_cases [5] = '{20'h1_1fea, 20'h0_1028, 20'h0_10fe,
		20'h0_0034, 20'h0_0077};

	assign sda_line = sda_drv & (~sda_oe | sda_out);
	always #20 clk = ~clk;

	sensing_threshold_registers dut (.clk(clk), .rst(rst), .otp_load(otp_load),
		.otp_bank(otp_bank), .i2c_mode(i2c_mode), .threshold_select_pin(threshold_select_pin),
		.scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .cfg(cfg));
	i2c_host_model host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		if (n_errors == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] rx;
		logic       ack;
		host.start();
		host.byte_io({sense_thr_pkg::dev_addr_default, 1'b0}, 1'b1, rx, ack);
		check(16'(ack), 16'h0000);
		host.byte_io(a, 1'b1, rx, ack);
		host.byte_io(d, 1'b1, rx, ack);
		check(16'(ack), 16'h0000);
		host.stop();
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] rx;
		logic       ack;
		host.start();
		host.byte_io({sense_thr_pkg::dev_addr_default, 1'b0}, 1'b1, rx, ack);
		host.byte_io(a, 1'b1, rx, ack);
		host.start();
		host.byte_io({sense_thr_pkg::dev_addr_default, 1'b1}, 1'b1, rx, ack);
		host.byte_io(8'hff, 1'b1, rx, ack);
		check(16'(rx), 16'(exp));
		host.stop();
	endtask

	initial begin
		repeat (32'h0000_ea60) @(posedge clk);
		n_errors++;
		summarize();
	end

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		otp_load = 1'b0;
		otp_bank = '0;
		i2c_mode = 1'b1;
		threshold_select_pin = 1'b0;
		n_errors = 0;
		total_checks = 0;
		repeat (4) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		check(16'(cfg.touch_threshold), 16'h0004);
		rdchk(sense_thr_pkg::near_level_addr, 8'h04);
		rdchk(sense_thr_pkg::drift_tracking_addr, 8'h03);
		otp_bank = '{touch_level: 8'hff, move_level: 8'h00, near_level: 4'h9};
		otp_load = 1'b1;
		@(negedge clk);
		otp_load = 1'b0;
		@(negedge clk);
		check(16'(cfg.touch_threshold), 16'h0400);
		check(16'(cfg.move_always), 16'h0001);
		check(16'(cfg.near_level), 16'h0009);
		rdchk(sense_thr_pkg::touch_level_addr, 8'hff);
		wr(sense_thr_pkg::touch_level_addr, 8'h05);
		check(16'(cfg.touch_threshold), 16'h0018);
		wr(sense_thr_pkg::move_level_addr, 8'h10);
		check(16'(cfg.move_level), 16'h0010);
		check(16'(cfg.move_always), 16'h0000);
		foreach (near_cases[i]) begin
			i2c_mode = near_cases[i][16];
			threshold_select_pin = near_cases[i][12];
			wr(sense_thr_pkg::near_level_addr, near_cases[i][11:4]);
			check(16'(cfg.near_level), 16'(near_cases[i][3:0]));
			rdchk(sense_thr_pkg::near_level_addr, {4'h0, near_cases[i][3:0]});
		end
		wr(sense_thr_pkg::drift_tracking_addr, 8'h01);
		check(16'(cfg.drift_rate), 16'h0001);
		wr(sense_thr_pkg::first_scaling_addr, 8'hff);
		check(16'(cfg.first_sens_mult), 16'h000f);
		check(16'(cfg.first_comp_mult), 16'h0003);
		rdchk(sense_thr_pkg::first_scaling_addr, 8'h3f);
		wr(sense_thr_pkg::second_scaling_addr, 8'h27);
		check(16'(cfg.second_sens_mult), 16'h0007);
		check(16'(cfg.second_comp_mult), 16'h0002);
		wr(sense_thr_pkg::first_trim_addr, 8'h5a);
		check(16'(cfg.first_trim), 16'h005a);
		wr(sense_thr_pkg::second_trim_addr, 8'ha5);
		check(16'(cfg.second_trim), 16'h00a5);
		rdchk(sense_thr_pkg::second_trim_addr, 8'ha5);
		rdchk(sense_thr_pkg::move_level_addr, 8'h10);
		check(16'(sda_out), 16'h0000);
		rdchk(8'h20, 8'h00);
		summarize();
	end
endmodule
